// ### src/dspcr_map.vh
// dspcr_map.vh: register offsets, field positions and reset values
// for the dsp core register-state block; included by dspcr_core.v.
// assumes a 32-bit apb slave with one register per aligned word.
`ifndef DSPCR_MAP_VH
`define DSPCR_MAP_VH
// apb byte offsets
`define DSPCR_OFF_CMD        12'h000
`define DSPCR_OFF_OPA        12'h004
`define DSPCR_OFF_OPB        12'h008
`define DSPCR_OFF_SUM        12'h00C
`define DSPCR_OFF_AUXSEL     12'h010
`define DSPCR_OFF_AUXDATA    12'h014
`define DSPCR_OFF_PTRS       12'h018
`define DSPCR_OFF_DIRADDR    12'h01C
`define DSPCR_OFF_IRQ        12'h020
`define DSPCR_OFF_PFC        12'h024
`define DSPCR_OFF_PC         12'h028
`define DSPCR_OFF_PROD       12'h02C
`define DSPCR_OFF_TREG       12'h030
`define DSPCR_OFF_RPT        12'h034
`define DSPCR_OFF_STAT       12'h038
`define DSPCR_OFF_INSTR      12'h03C
`define DSPCR_OFF_STACK      12'h040
// command codes, written to bits 4:0 of the command register
`define DSPCR_CMD_ALU_ADD    5'h01
`define DSPCR_CMD_ALU_SUB    5'h02
`define DSPCR_CMD_ALU_AND    5'h03
`define DSPCR_CMD_ALU_OR     5'h04
`define DSPCR_CMD_ALU_XOR    5'h05
`define DSPCR_CMD_AUX_ADD    5'h06
`define DSPCR_CMD_AUX_SUB    5'h07
`define DSPCR_CMD_LD_PTR     5'h08
`define DSPCR_CMD_LD_ST0     5'h09
`define DSPCR_CMD_LD_ST1     5'h0A
`define DSPCR_CMD_MUL        5'h0B
`define DSPCR_CMD_BORROW     5'h0C
`define DSPCR_CMD_RESTORE    5'h0D
`define DSPCR_CMD_PREFETCH   5'h0E
`define DSPCR_CMD_DECODE     5'h0F
`define DSPCR_CMD_PUSH_PC    5'h10
`define DSPCR_CMD_PUSH_SUML  5'h11
`define DSPCR_CMD_PUSH_DATA  5'h12
`define DSPCR_CMD_POP        5'h13
`define DSPCR_CMD_RPT_STEP   5'h14
// field positions
`define DSPCR_ARB_LSB        8
`define DSPCR_DP_LSB         16
`define DSPCR_ST1_ARB_LSB    13
// reset values
`define DSPCR_RST_W16        16'h0000
`define DSPCR_RST_W32        32'h0000_0000
`endif

// ### src/dspcr_core.v
// dspcr_core.v: architectural register state of a 16-bit fixed-point
// dsp core, reached over apb. assumes a single clock and that software
// drives the core's micro-operations through the command register.
`timescale 1ns/1ps
`include "dspcr_map.vh"
module dspcr_core #(
  parameter AUX_COUNT   = 8,     // auxiliary registers selectable, 5 or 8
  parameter STACK_DEPTH = 8      // hardware stack entries, 4 or 8
) (
  input  wire        pclk,          // core clock, 40 mhz
  input  wire        presetn,       // asynchronous reset, active low
  input  wire        psel,          // apb select
  input  wire        penable,       // apb access phase
  input  wire        pwrite,        // apb direction, 1 = write
  input  wire [11:0] paddr,         // apb byte address
  input  wire [31:0] pwdata,        // apb write data
  output reg  [31:0] prdata,        // apb read data
  output reg         pready,        // apb ready
  output reg         pslverr,       // apb error, unmapped address
  input  wire [2:0]  ext_irq_lines_n, // external interrupts, active low
  input  wire        ser_tx_irq,    // serial transmit interrupt
  input  wire        ser_rx_irq,    // serial receive interrupt
  input  wire        timer_irq,     // timer interrupt
  output reg  [15:0] aux_file_bus,  // selected auxiliary register
  output reg  [15:0] direct_addr_bus, // page plus instruction offset
  output reg  [15:0] pfc_mem_addr,  // borrowed prefetch address
  output reg         pfc_addr_data, // 1: address is data space
  output reg  [5:0]  irq_pending    // flags gated by mask
);

  // command phase: each command acts one cycle after its apb write
  reg [4:0]  cmd;                 // pending command code
  reg        cmd_valid;           // pending command strobe
  reg [2:0]  cmd_op;              // borrow opcode kind
  reg [31:0] opa;                 // alu operand a / general argument
  reg [31:0] opb;                 // alu operand b
  reg [31:0] sum_register;        // alu result
  reg [15:0] aux_regs [0:7];      // auxiliary register file
  reg [2:0]  aux_sel;             // software index into aux file
  reg [2:0]  aux_pointer;         // active auxiliary register
  reg [2:0]  aux_pointer_buffer;  // previous pointer value
  reg [8:0]  page_pointer;        // data page
  reg [5:0]  irq_flags;           // latched sources
  reg [5:0]  irq_mask;            // 1 = source enabled
  reg [15:0] prefetch_counter;    // address being prefetched
  reg [15:0] micro_call_slot;     // saved prefetch counter
  reg        pfc_borrowed;        // counter lent to a move/mac
  reg [15:0] prog_counter;        // next instruction address
  reg [31:0] mul_result_reg;      // product
  reg [15:0] multiplicand_reg;    // multiplier operand / shift count
  reg [7:0]  repeat_counter;      // repeat count
  reg [15:0] status_word0;        // status and control word 0
  reg [15:0] status_word1;        // status and control word 1
  reg [15:0] instr_reg;           // executing instruction
  reg [15:0] queued_instr_reg;    // prefetched instruction
  reg [15:0] hw_stack [0:7];      // hardware stack storage
  reg [3:0]  stack_cnt;           // entries in use
  reg [15:0] stack_top;           // last popped value
  integer    i;                   // aux file reset index
  integer    j;                   // stack reset index, own driver

  wire        wr_en = psel & penable & pwrite;     // write takes effect
  wire        rd_en = psel & penable & ~pwrite;    // read is sampled
  wire [31:0] alu_sum  = opa + opb;                // two's-complement add
  wire [31:0] alu_diff = opa - opb;                // two's-complement sub
  wire [2:0]  aux_max  = AUX_COUNT[2:0] - 3'd1;    // highest pointer value
  wire [2:0]  ptr_arg  = (opa[2:0] > aux_max) ? aux_max : opa[2:0];
  wire [15:0] aux_cur  = aux_regs[aux_pointer];    // pointer-selected entry
  wire        stk_full = (stack_cnt == STACK_DEPTH[3:0]);
  wire [5:0]  irq_src  = {timer_irq, ser_rx_irq, ser_tx_irq, ~ext_irq_lines_n};

  // apb slave: zero-wait answer, errors on unmapped addresses
  reg        addr_ok;              // address decodes to a register
  reg [31:0] rd_mux;               // selected read value
  always @*
  begin
    addr_ok = 1'b1;
    rd_mux  = 32'h0000_0000;
    if (paddr == `DSPCR_OFF_CMD)
      rd_mux = {27'h000_0000, cmd};
    else if (paddr == `DSPCR_OFF_OPA)
      rd_mux = opa;
    else if (paddr == `DSPCR_OFF_OPB)
      rd_mux = opb;
    else if (paddr == `DSPCR_OFF_SUM)
      rd_mux = sum_register;
    else if (paddr == `DSPCR_OFF_AUXSEL)
      rd_mux = {29'h0000_0000, aux_sel};
    else if (paddr == `DSPCR_OFF_AUXDATA)
      rd_mux = {16'h0000, aux_regs[aux_sel]};
    else if (paddr == `DSPCR_OFF_PTRS)
      rd_mux = {7'h00, page_pointer, 5'h00, aux_pointer_buffer, 5'h00, aux_pointer};
    else if (paddr == `DSPCR_OFF_DIRADDR)
      rd_mux = {16'h0000, direct_addr_bus};
    else if (paddr == `DSPCR_OFF_IRQ)
      rd_mux = {26'h000_0000, irq_mask};    // flags have no read path
    else if (paddr == `DSPCR_OFF_PFC)
      rd_mux = {micro_call_slot, prefetch_counter};
    else if (paddr == `DSPCR_OFF_PC)
      rd_mux = {16'h0000, prog_counter};
    else if (paddr == `DSPCR_OFF_PROD)
      rd_mux = mul_result_reg;
    else if (paddr == `DSPCR_OFF_TREG)
      rd_mux = {16'h0000, multiplicand_reg};
    else if (paddr == `DSPCR_OFF_RPT)
      rd_mux = {24'h00_0000, repeat_counter};
    else if (paddr == `DSPCR_OFF_STAT)
      rd_mux = {status_word1, status_word0};
    else if (paddr == `DSPCR_OFF_INSTR)
      rd_mux = {queued_instr_reg, instr_reg};
    else if (paddr == `DSPCR_OFF_STACK)
      rd_mux = {12'h000, stack_cnt, stack_top};
    else
      addr_ok = 1'b0;
  end

  // bus answer registers: ready follows setup by one cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= `DSPCR_RST_W32;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;      // no wait state: ready in the first access cycle
      prdata  <= (psel & ~penable & ~pwrite & addr_ok) ? rd_mux : 32'h0000_0000;
      pslverr <= psel & ~penable & ~addr_ok;
    end
  end

  // software registers and command capture
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd       <= 5'h00;
      cmd_valid <= 1'b0;
      opa       <= `DSPCR_RST_W32;
      opb       <= `DSPCR_RST_W32;
      aux_sel   <= 3'h0;
      irq_mask  <= 6'h00;
    end
    else
    begin
      cmd_valid <= 1'b0;
      if (wr_en & pready & addr_ok)
      begin
        if (paddr == `DSPCR_OFF_CMD)
        begin
          cmd       <= pwdata[4:0];
          cmd_valid <= 1'b1;
        end
        else if (paddr == `DSPCR_OFF_OPA)
          opa <= pwdata;
        else if (paddr == `DSPCR_OFF_OPB)
          opb <= pwdata;
        else if (paddr == `DSPCR_OFF_AUXSEL)
          aux_sel <= pwdata[2:0];
        else if (paddr == `DSPCR_OFF_IRQ)
          irq_mask <= pwdata[5:0];
      end
    end
  end

  // sum register from the 32-bit alu
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sum_register <= `DSPCR_RST_W32;
    else if (cmd_valid)
    begin
      case (cmd)
        `DSPCR_CMD_ALU_ADD: sum_register <= alu_sum;
        `DSPCR_CMD_ALU_SUB: sum_register <= alu_diff;
        `DSPCR_CMD_ALU_AND: sum_register <= opa & opb;
        `DSPCR_CMD_ALU_OR:  sum_register <= opa | opb;
        `DSPCR_CMD_ALU_XOR: sum_register <= opa ^ opb;
        default:            sum_register <= sum_register;
      endcase
    end
  end

  // auxiliary file: software writes, plus the unsigned aux unit on the
  // pointer-selected entry; wraps modulo 2^16, no flags
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (i = 0; i < 8; i = i + 1)
        aux_regs[i] <= `DSPCR_RST_W16;
    end
    else if (wr_en & pready & (paddr == `DSPCR_OFF_AUXDATA))
      aux_regs[aux_sel] <= pwdata[15:0];
    else if (cmd_valid & (cmd == `DSPCR_CMD_AUX_ADD))
      aux_regs[aux_pointer] <= aux_cur + opa[15:0];
    else if (cmd_valid & (cmd == `DSPCR_CMD_AUX_SUB))
      aux_regs[aux_pointer] <= aux_cur - opa[15:0];
  end

  // pointer, pointer buffer, page pointer and status words
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      aux_pointer        <= 3'h0;
      aux_pointer_buffer <= 3'h0;
      page_pointer       <= 9'h000;
      status_word0       <= `DSPCR_RST_W16;
      status_word1       <= `DSPCR_RST_W16;
    end
    else if (cmd_valid)
    begin
      case (cmd)
        `DSPCR_CMD_LD_PTR:
        begin
          aux_pointer_buffer <= aux_pointer;
          aux_pointer        <= ptr_arg;
          page_pointer       <= opa[`DSPCR_DP_LSB+8:`DSPCR_DP_LSB];
        end
        `DSPCR_CMD_LD_ST0:
        begin
          status_word0 <= opa[15:0];
          aux_pointer  <= ptr_arg;     // buffer untouched
        end
        `DSPCR_CMD_LD_ST1:
        begin
          status_word1       <= opa[15:0];
          aux_pointer_buffer <= opa[`DSPCR_ST1_ARB_LSB+2:`DSPCR_ST1_ARB_LSB];
          aux_pointer        <= opa[`DSPCR_ST1_ARB_LSB+2:`DSPCR_ST1_ARB_LSB];
        end
        default:
        begin
          aux_pointer <= aux_pointer;
        end
      endcase
    end
  end

  // interrupt flags: set wins over clear; clear only by the decode command
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_flags <= 6'h00;
    else if (cmd_valid & (cmd == `DSPCR_CMD_DECODE))
      irq_flags <= (irq_flags & ~opa[21:16]) | irq_src;
    else
      irq_flags <= irq_flags | irq_src;
  end

  // prefetch counter, micro-call slot, program counter, instruction regs
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prefetch_counter <= `DSPCR_RST_W16;
      micro_call_slot  <= `DSPCR_RST_W16;
      pfc_borrowed     <= 1'b0;
      cmd_op           <= 3'h0;
      prog_counter     <= `DSPCR_RST_W16;
      instr_reg        <= `DSPCR_RST_W16;
      queued_instr_reg <= `DSPCR_RST_W16;
    end
    else if (cmd_valid)
    begin
      case (cmd)
        `DSPCR_CMD_PREFETCH:
        begin
          prefetch_counter <= opa[15:0];
          queued_instr_reg <= opb[15:0];
        end
        `DSPCR_CMD_BORROW:
        begin
          micro_call_slot  <= prefetch_counter;
          prefetch_counter <= opa[15:0];
          cmd_op           <= opb[2:0];    // 0 = data-space block move
          pfc_borrowed     <= 1'b1;
        end
        `DSPCR_CMD_RESTORE:
        begin
          prefetch_counter <= micro_call_slot;
          pfc_borrowed     <= 1'b0;
        end
        `DSPCR_CMD_DECODE:
        begin
          instr_reg    <= queued_instr_reg;
          prog_counter <= opa[15:0];
        end
        default:
        begin
          pfc_borrowed <= pfc_borrowed;
        end
      endcase
    end
  end

  // multiplier, multiplicand and repeat counter
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mul_result_reg   <= `DSPCR_RST_W32;
      multiplicand_reg <= `DSPCR_RST_W16;
      repeat_counter   <= 8'h00;
    end
    else if (wr_en & pready & (paddr == `DSPCR_OFF_TREG))
      multiplicand_reg <= pwdata[15:0];
    else if (wr_en & pready & (paddr == `DSPCR_OFF_RPT))
      repeat_counter <= pwdata[7:0];
    else if (cmd_valid & (cmd == `DSPCR_CMD_MUL))
      mul_result_reg <= $signed(multiplicand_reg) * $signed(opa[15:0]);
    else if (cmd_valid & (cmd == `DSPCR_CMD_RPT_STEP) & (repeat_counter != 8'h00))
      repeat_counter <= repeat_counter - 8'h01;
  end

  // hardware stack: push refused when full, pop ignored when empty
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stack_cnt <= 4'h0;
      stack_top <= `DSPCR_RST_W16;
      for (j = 0; j < 8; j = j + 1)
        hw_stack[j] <= `DSPCR_RST_W16;
    end
    else if (cmd_valid & ~stk_full & (cmd == `DSPCR_CMD_PUSH_PC))
    begin
      hw_stack[stack_cnt[2:0]] <= prog_counter;
      stack_cnt <= stack_cnt + 4'h1;
    end
    else if (cmd_valid & ~stk_full & (cmd == `DSPCR_CMD_PUSH_SUML))
    begin
      hw_stack[stack_cnt[2:0]] <= sum_register[15:0];
      stack_cnt <= stack_cnt + 4'h1;
    end
    else if (cmd_valid & ~stk_full & (cmd == `DSPCR_CMD_PUSH_DATA))
    begin
      hw_stack[stack_cnt[2:0]] <= opa[15:0];
      stack_cnt <= stack_cnt + 4'h1;
    end
    else if (cmd_valid & (stack_cnt != 4'h0) & (cmd == `DSPCR_CMD_POP))
    begin
      stack_top <= hw_stack[stack_cnt[2:0] - 3'd1];
      stack_cnt <= stack_cnt - 4'h1;
    end
  end

  // registered outputs
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      aux_file_bus    <= `DSPCR_RST_W16;
      direct_addr_bus <= `DSPCR_RST_W16;
      pfc_mem_addr    <= `DSPCR_RST_W16;
      pfc_addr_data   <= 1'b0;
      irq_pending     <= 6'h00;
    end
    else
    begin
      aux_file_bus    <= aux_cur;
      direct_addr_bus <= {page_pointer, instr_reg[6:0]};
      pfc_mem_addr    <= pfc_borrowed ? prefetch_counter : 16'h0000;
      pfc_addr_data   <= pfc_borrowed & (cmd_op == 3'h0);
      irq_pending     <= irq_flags & irq_mask;
    end
  end

endmodule // dspcr_core

// ### tb/dspcr_monitor.sv
// dspcr_monitor.sv: port-level assertions for dspcr_core, bound below
// assumes one pclk domain and presetn asynchronous, active low
`timescale 1ns/1ps
module dspcr_mon (
  input wire        pclk,            // core clock
  input wire        presetn,         // async reset, active low
  input wire        psel,            // apb select
  input wire        penable,         // apb access phase
  input wire        pwrite,          // apb direction
  input wire [31:0] prdata,          // apb read data
  input wire        pready,          // apb ready
  input wire        pslverr,         // apb error
  input wire [15:0] aux_file_bus,    // selected auxiliary register
  input wire [15:0] direct_addr_bus, // direct address
  input wire [15:0] pfc_mem_addr,    // borrowed prefetch address
  input wire        pfc_addr_data,   // borrowed for data space
  input wire [5:0]  irq_pending      // masked flags
);
  reg [3:0] since_wr; // edges since last completed write, saturating

  // apart from flags set by interrupt sources, state only moves after software writes, so count from the last one
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      since_wr <= 4'hF;
    else if (psel && penable && pready && pwrite)
      since_wr <= 4'h0;
    else if (since_wr != 4'hF)
      since_wr <= since_wr + 4'h1;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_ready_soon: assert property ($rose(psel) |-> ##[1:4] pready)
    else $error("no pready after setup");
  chk_err_zero: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("error response with nonzero read data");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_aux_quiet: assert property ($changed(aux_file_bus) |-> since_wr <= 4'h4)
    else $error("aux bus moved with no write");
  chk_direct_quiet: assert property ($changed(direct_addr_bus) |-> since_wr <= 4'h4)
    else $error("direct address moved with no write");
  chk_pfc_quiet: assert property ($changed(pfc_mem_addr) |-> since_wr <= 4'h4)
    else $error("prefetch address moved with no write");
  chk_flag_hold: assert property (|($past(irq_pending) & ~irq_pending) |-> since_wr <= 4'h4)
    else $error("pending flag dropped with no write");

  cover property (pready && pslverr);
  cover property (pfc_addr_data);
  cover property (|irq_pending);
endmodule // dspcr_mon

bind dspcr_core dspcr_mon mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .aux_file_bus(aux_file_bus), .direct_addr_bus(direct_addr_bus),
  .pfc_mem_addr(pfc_mem_addr), .pfc_addr_data(pfc_addr_data), .irq_pending(irq_pending));

// ### tb/tb.sv
// tb.sv: self-checking bench for dspcr_core, driven as an apb master
// assumes the core answers each access with pready within a few cycles
`timescale 1ns/1ps
`include "dspcr_map.vh"
module tb;
  reg         pclk;            // 40 mhz core clock
  reg         presetn;         // async reset, active low
  reg         psel;            // apb select
  reg         penable;         // apb access phase
  reg         pwrite;          // apb direction
  reg  [11:0] paddr;           // apb byte address
  reg  [31:0] pwdata;          // apb write data
  wire [31:0] prdata;          // apb read data
  wire        pready;          // apb ready
  wire        pslverr;         // apb error
  reg  [2:0]  ext_irq_lines_n; // external interrupts, active low
  reg         ser_tx_irq;      // serial transmit source
  reg         ser_rx_irq;      // serial receive source
  reg         timer_irq;       // timer source
  wire [15:0] aux_file_bus;    // selected auxiliary register
  wire [15:0] direct_addr_bus; // direct address
  wire [15:0] pfc_mem_addr;    // borrowed prefetch address
  wire        pfc_addr_data;   // borrowed for data space
  wire [5:0]  irq_pending;     // masked flags
  integer     bad_count;       // mismatches
  integer     checks_done;     // comparisons
  reg  [31:0] rd;              // last read data
  reg         er;              // last error response
  integer     i;               // loop index
  localparam [31:0] OA = 32'h8000_0001; // alu operand a
  localparam [31:0] OB = 32'hFFFF_0003; // alu operand b

  dspcr_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq_lines_n(ext_irq_lines_n), .ser_tx_irq(ser_tx_irq),
    .ser_rx_irq(ser_rx_irq), .timer_irq(timer_irq), .aux_file_bus(aux_file_bus),
    .direct_addr_bus(direct_addr_bus), .pfc_mem_addr(pfc_mem_addr),
    .pfc_addr_data(pfc_addr_data), .irq_pending(irq_pending));

  // 25 ns period
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
        bad_count = bad_count + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // one apb transfer; the request stands until pready is sampled high
  task xfer(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // no limit here: a stuck slave is caught by the watchdog
      while (pready !== 1'b1)
        @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task wr(input [11:0] a, input [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rdchk(input [11:0] a, input [31:0] exp);
    begin
      xfer(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
    end
  endtask

  // a command acts and its outputs settle within three edges
  task cmd(input [4:0] c);
    begin
      wr(`DSPCR_OFF_CMD, {27'h000_0000, c});
      repeat (3) @(posedge pclk);
    end
  endtask

  task op(input [31:0] a, input [31:0] b);
    begin
      wr(`DSPCR_OFF_OPA, a);
      wr(`DSPCR_OFF_OPB, b);
    end
  endtask

  task complete_run;
    begin
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  // watchdog: the tests need about 700 cycles, allow 8000
  initial
  begin
    #200000;
    bad_count = bad_count + 1;
    complete_run;
  end

  initial
  begin
    bad_count = 0;
    checks_done = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = 47'h0000_0000_0000;
    ext_irq_lines_n = 3'b111;
    {ser_tx_irq, ser_rx_irq, timer_irq} = 3'b000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // every readable register from the sum register up starts at zero
    for (i = 3; i < 17; i = i + 1)
      rdchk(12'(4 * i), 32'h0000_0000);
    $display("test reset done");
    op(OA, OB);
    for (i = 1; i < 6; i = i + 1)
    begin
      cmd(5'(i));
      rdchk(`DSPCR_OFF_SUM, (i == 1) ? OA + OB : (i == 2) ? OA - OB : (i == 3) ? (OA & OB) :
        (i == 4) ? (OA | OB) : (OA ^ OB));
    end
    $display("test alu done");
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(`DSPCR_OFF_AUXSEL, i);
      wr(`DSPCR_OFF_AUXDATA, 32'h0000_1000 + i);
      rdchk(`DSPCR_OFF_AUXDATA, 32'h0000_1000 + i);
    end
    op(32'h01A5_0003, 32'h0000_0000);
    cmd(`DSPCR_CMD_LD_PTR);
    chk(aux_file_bus, 32'h0000_1003);
    rdchk(`DSPCR_OFF_PTRS, 32'h01A5_0003);
    // unsigned wrap of the auxiliary unit
    op(32'h0000_FFFF, 32'h0000_0000);
    cmd(`DSPCR_CMD_AUX_ADD);
    chk(aux_file_bus, 32'h0000_1002);
    op(32'h01A5_0006, 32'h0000_0000);
    cmd(`DSPCR_CMD_LD_PTR);
    rdchk(`DSPCR_OFF_PTRS, 32'h01A5_0306);
    chk(aux_file_bus, 32'h0000_1006);
    op(32'h0000_0001, 32'h0000_0000);
    cmd(`DSPCR_CMD_LD_ST0);
    rdchk(`DSPCR_OFF_PTRS, 32'h01A5_0301);
    op(32'h0000_A000, 32'h0000_0000);
    cmd(`DSPCR_CMD_LD_ST1);
    rdchk(`DSPCR_OFF_PTRS, 32'h01A5_0505);
    rdchk(`DSPCR_OFF_STAT, 32'hA000_0001);
    $display("test pointers done");
    op(32'h0000_1234, 32'h0000_00FF);
    cmd(`DSPCR_CMD_PREFETCH);
    op(32'h0000_0055, 32'h0000_0000);
    cmd(`DSPCR_CMD_DECODE);
    rdchk(`DSPCR_OFF_PC, 32'h0000_0055);
    rdchk(`DSPCR_OFF_INSTR, 32'h00FF_00FF);
    rdchk(`DSPCR_OFF_PFC, 32'h0000_1234);
    chk(direct_addr_bus, 32'h0000_D2FF);
    for (i = 0; i < 6; i = i + 1)
    begin
      op(32'h0000_BEE0 + i, i);
      cmd(`DSPCR_CMD_BORROW);
      rdchk(`DSPCR_OFF_PFC, 32'h1234_BEE0 + i);
      chk(pfc_mem_addr, 32'h0000_BEE0 + i);
      chk(pfc_addr_data, i == 0);
      cmd(`DSPCR_CMD_RESTORE);
      chk(pfc_mem_addr, 32'h0000_0000);
    end
    $display("test prefetch done");
    wr(`DSPCR_OFF_TREG, 32'h0000_FFFE);
    rdchk(`DSPCR_OFF_TREG, 32'h0000_FFFE);
    op(32'h0000_0003, 32'h0000_0000);
    cmd(`DSPCR_CMD_MUL);
    rdchk(`DSPCR_OFF_PROD, 32'hFFFF_FFFA);
    wr(`DSPCR_OFF_RPT, 32'h0000_0101);
    rdchk(`DSPCR_OFF_RPT, 32'h0000_0001);
    cmd(`DSPCR_CMD_RPT_STEP);
    cmd(`DSPCR_CMD_RPT_STEP);
    rdchk(`DSPCR_OFF_RPT, 32'h0000_0000);
    $display("test multiply done");
    // nine pushes into eight entries: the last is dropped
    for (i = 0; i < 9; i = i + 1)
    begin
      op(32'h0000_5A00 + i, 32'h0000_0000);
      cmd(`DSPCR_CMD_PUSH_DATA);
    end
    rdchk(`DSPCR_OFF_STACK, 32'h0008_0000);
    for (i = 7; i >= 0; i = i - 1)
    begin
      cmd(`DSPCR_CMD_POP);
      rdchk(`DSPCR_OFF_STACK, {12'h000, 4'(i), 16'(16'h5A00 + i)});
    end
    cmd(`DSPCR_CMD_POP);
    rdchk(`DSPCR_OFF_STACK, 32'h0000_5A00);
    cmd(`DSPCR_CMD_PUSH_PC);
    cmd(`DSPCR_CMD_POP);
    rdchk(`DSPCR_OFF_STACK, 32'h0000_0055);
    cmd(`DSPCR_CMD_PUSH_SUML);
    cmd(`DSPCR_CMD_POP);
    rdchk(`DSPCR_OFF_STACK, {16'h0000, OA[15:0] ^ OB[15:0]});
    $display("test stack done");
    wr(`DSPCR_OFF_IRQ, 32'h0000_003F);
    rdchk(`DSPCR_OFF_IRQ, 32'h0000_003F);
    // one-cycle pulses must stay latched
    @(posedge pclk);
    ext_irq_lines_n <= 3'b010;
    {ser_tx_irq, ser_rx_irq, timer_irq} <= 3'b111;
    @(posedge pclk);
    ext_irq_lines_n <= 3'b111;
    {ser_tx_irq, ser_rx_irq, timer_irq} <= 3'b000;
    repeat (3) @(posedge pclk);
    chk(irq_pending, 32'h0000_003D);
    wr(`DSPCR_OFF_IRQ, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    chk(irq_pending, 32'h0000_0001);
    rdchk(`DSPCR_OFF_IRQ, 32'h0000_0001);
    op(32'h003F_0055, 32'h0000_0000);
    cmd(`DSPCR_CMD_DECODE);
    wr(`DSPCR_OFF_IRQ, 32'h0000_003F);
    repeat (3) @(posedge pclk);
    chk(irq_pending, 32'h0000_0000);
    $display("test interrupts done");
    // unmapped word refused both ways
    xfer(1'b1, 12'h044, 32'hFFFF_FFFF);
    chk(er, 1'b1);
    xfer(1'b0, 12'h044, 32'h0000_0000);
    chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    $display("test unmapped done");
    complete_run;
  end
endmodule // tb
